// ### lcd_serial_store.v
// serial display link receiver, display memory and row refresh scan
//
// Notes on behaviour
// [R01] memory of six banks, 84 bytes each
// [R02] column and bank addresses load separately
// [R03] address advances one step per data byte
// [R04] host loads only column 0-83, bank 0-5
// [R05] vertical mode advances bank each byte
// [R06] vertical: after bank 5, bank 0, column+1
// [R07] horizontal mode advances column each byte
// [R08] horizontal: after column 83, column 0, bank+1
// [R09] column 83 bank 5 wraps to zero
// [R10] column address maps to same column output
// [R11] bits accepted only while select is low
// [R12] reset input reinitialises the block
// [R13] mode input marks command or data byte
// [R14] two bits choose blank/on/normal/inverse display
// [R15] two bits choose temperature coefficient
// [R16] host enters power-down before stopping clock
// [R17] refresh runs independent of serial traffic
// [R18] refresh scans 48 rows onto 84 columns
// [R19] data sampled on rising edge, MSB first
// [R20] mode level taken on eighth clock pulse
// [R21] select high holds bit counter at start
// [R22] reset clears addresses, picks horizontal mode
// [R23] byte bit 0 is top row of bank
`timescale 1ns/10ps
`include "lcd_store_map.vh"

module lcd_serial_store #(
    parameter BUF_DEPTH = 2,
    parameter BUF_AW = 1,
    parameter COLS = 84,
    parameter ROWS = 48
) (
    // clock and reset
    input wire MCLK,
    input wire RESETN,
    // serial link
    input wire SERIAL_CLOCK,
    input wire SERIAL_DATA_IN,
    input wire LINK_SELECT_N,
    input wire DATA_MODE,
    // display clock
    input wire DISPLAY_CLOCK_INPUT,
    // panel drive
    output reg [ROWS-1:0] ROW_SELECT,
    output reg [COLS-1:0] COLUMN_OUT,
    // status
    output reg [6:0] COLUMN_ADDRESS,
    output reg [2:0] BANK_ADDRESS,
    output reg VERTICAL_MODE,
    output reg EXTENDED_SET,
    output reg [1:0] DISPLAY_MODE,
    output reg POWER_DOWN_FLAG,
    output reg TEMP_COEFF_MSB,
    output reg TEMP_COEFF_LSB,
    output reg BYTE_OVERRUN
);

    localparam [BUF_AW:0] BUF_FULL = BUF_DEPTH;
    localparam [1:0] TC_INIT = `TC_RESET;

    // memory index of a bank and column
    function [8:0] mem_index;
        input [2:0] bank;
        input [6:0] col;
        begin
            mem_index = bank * `COL_COUNT + {2'h0, col}; // [R01] [R04]
        end
    endfunction

    // next write address as {bank, column}
    function [9:0] next_addr;
        input vert;
        input [2:0] bank;
        input [6:0] col;
        reg [6:0] col_inc;
        reg [2:0] bank_inc;
        begin
            col_inc = col + 7'h01;
            bank_inc = bank + 3'h1;
            if (col == `COL_LAST && bank == `BANK_LAST) begin
                next_addr = {`BANK_RESET, `COL_RESET}; // [R09]
            end else if (vert) begin
                if (bank == `BANK_LAST) begin
                    next_addr = {`BANK_RESET, col_inc}; // [R06]
                end else begin
                    next_addr = {bank_inc, col}; // [R05]
                end
            end else begin
                if (col == `COL_LAST) begin
                    next_addr = {bank_inc, `COL_RESET}; // [R08]
                end else begin
                    next_addr = {bank, col_inc}; // [R07]
                end
            end
        end
    endfunction

    // shape a row for the presentation mode
    function [COLS-1:0] shape_row;
        input [1:0] mode;
        input [COLS-1:0] line;
        begin
            case (mode)
                `DM_BLANK: shape_row = {COLS{1'b0}};
                `DM_ALLON: shape_row = {COLS{1'b1}};
                `DM_NORMAL: shape_row = line;
                `DM_INVERSE: shape_row = ~line;
                default: shape_row = {COLS{1'b0}};
            endcase
        end
    endfunction

    // input synchronisers
    reg sclk_s1_r, sclk_s2_r, sclk_s3_r;
    reg serial_data_in_s1_r, serial_data_in_s2_r;
    reg sel_s1_r, sel_s2_r;
    reg dc_s1_r, dc_s2_r;
    reg dclk_s1_r, dclk_s2_r, dclk_s3_r;

    always @(posedge MCLK) begin
        if (!RESETN) begin
            sclk_s1_r <= 1'b0;
            sclk_s2_r <= 1'b0;
            sclk_s3_r <= 1'b0;
            serial_data_in_s1_r <= 1'b0;
            serial_data_in_s2_r <= 1'b0;
            sel_s1_r <= 1'b1;
            sel_s2_r <= 1'b1;
            dc_s1_r <= 1'b0;
            dc_s2_r <= 1'b0;
            dclk_s1_r <= 1'b0;
            dclk_s2_r <= 1'b0;
            dclk_s3_r <= 1'b0;
        end else begin
            sclk_s1_r <= SERIAL_CLOCK;
            sclk_s2_r <= sclk_s1_r;
            sclk_s3_r <= sclk_s2_r;
            serial_data_in_s1_r <= SERIAL_DATA_IN;
            serial_data_in_s2_r <= serial_data_in_s1_r;
            sel_s1_r <= LINK_SELECT_N;
            sel_s2_r <= sel_s1_r;
            dc_s1_r <= DATA_MODE;
            dc_s2_r <= dc_s1_r;
            dclk_s1_r <= DISPLAY_CLOCK_INPUT;
            dclk_s2_r <= dclk_s1_r;
            dclk_s3_r <= dclk_s2_r;
        end
    end

    wire sclk_rise = sclk_s2_r & ~sclk_s3_r;
    wire dclk_rise = dclk_s2_r & ~dclk_s3_r;

    // serial receiver
    reg [2:0] bit_cnt_r;
    reg [6:0] shift_r;
    wire bit_take = sclk_rise & ~sel_s2_r; // [R11]
    wire rx_push = bit_take && (bit_cnt_r == `BIT_LAST);
    wire [8:0] rx_entry = {dc_s2_r, shift_r, serial_data_in_s2_r}; // [R20]
    wire buf_in_ready;

    always @(posedge MCLK) begin
        if (!RESETN) begin
            bit_cnt_r <= 3'h0; // [R12]
            shift_r <= 7'h00;
            BYTE_OVERRUN <= 1'b0;
        end else begin
            if (sel_s2_r) begin
                bit_cnt_r <= 3'h0; // [R21]
            end else if (bit_take) begin
                bit_cnt_r <= bit_cnt_r + 3'h1;
                shift_r <= {shift_r[5:0], serial_data_in_s2_r}; // [R19]
            end
            if (rx_push && !buf_in_ready) begin
                BYTE_OVERRUN <= 1'b1;
            end
        end
    end

    // two-entry byte buffer
    reg [8:0] buf_mem_r [0:BUF_DEPTH-1];
    reg [BUF_AW-1:0] wr_ptr_r;
    reg [BUF_AW-1:0] rd_ptr_r;
    reg [BUF_AW:0] count_r;
    reg scan_busy_r;
    wire buf_out_valid = (count_r != {(BUF_AW+1){1'b0}});
    wire buf_out_ready = ~scan_busy_r;
    wire buf_push = rx_push & buf_in_ready;
    wire buf_pop = buf_out_valid & buf_out_ready;
    wire [8:0] buf_out = buf_mem_r[rd_ptr_r];
    assign buf_in_ready = (count_r != BUF_FULL);

    always @(posedge MCLK) begin
        if (buf_push) begin
            buf_mem_r[wr_ptr_r] <= rx_entry;
        end
    end

    always @(posedge MCLK) begin
        if (!RESETN) begin
            wr_ptr_r <= {BUF_AW{1'b0}};
            rd_ptr_r <= {BUF_AW{1'b0}};
            count_r <= {(BUF_AW+1){1'b0}};
        end else begin
            if (buf_push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (buf_pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (buf_push && !buf_pop) begin
                count_r <= count_r + 1'b1;
            end else if (buf_pop && !buf_push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

    // display memory
    reg [7:0] display_memory [0:6*COLS-1]; // [R01]
    wire [7:0] wr_byte = buf_out[`ENTRY_BYTE];
    wire wr_data = buf_pop & buf_out[`ENTRY_DC]; // [R13]
    wire wr_cmd = buf_pop & ~buf_out[`ENTRY_DC]; // [R13]
    wire [9:0] addr_nxt = next_addr(VERTICAL_MODE, BANK_ADDRESS,
        COLUMN_ADDRESS);

    always @(posedge MCLK) begin
        if (wr_data) begin
            display_memory[mem_index(BANK_ADDRESS, COLUMN_ADDRESS)]
                <= wr_byte;
        end
    end

    // command decode and write address counter
    always @(posedge MCLK) begin
        if (!RESETN) begin
            COLUMN_ADDRESS <= `COL_RESET; // [R22]
            BANK_ADDRESS <= `BANK_RESET; // [R22]
            VERTICAL_MODE <= `V_RESET; // [R22]
            EXTENDED_SET <= `H_RESET;
            POWER_DOWN_FLAG <= `PD_RESET; // [R12]
            DISPLAY_MODE <= `DM_RESET;
            TEMP_COEFF_MSB <= TC_INIT[1];
            TEMP_COEFF_LSB <= TC_INIT[0];
        end else if (wr_data) begin
            BANK_ADDRESS <= addr_nxt[9:7]; // [R03]
            COLUMN_ADDRESS <= addr_nxt[6:0]; // [R03]
        end else if (wr_cmd) begin
            if (wr_byte[`CMD_HI5] == `CMD_FSET_OP) begin
                POWER_DOWN_FLAG <= wr_byte[`FS_PD];
                VERTICAL_MODE <= wr_byte[`FS_V];
                EXTENDED_SET <= wr_byte[`FS_H];
            end else if (!EXTENDED_SET) begin
                if (wr_byte[`CMD_SETX_BIT]) begin
                    COLUMN_ADDRESS <= wr_byte[`FLD_X]; // [R02]
                end else if (wr_byte[`CMD_HI5] == `CMD_SETY_OP) begin
                    BANK_ADDRESS <= wr_byte[`FLD_Y]; // [R02]
                end else if (wr_byte[`CMD_HI5] == `CMD_DCTL_OP &&
                    !wr_byte[`DC_ZERO]) begin
                    DISPLAY_MODE <= {wr_byte[`DC_D], wr_byte[`DC_E]}; // [R14]
                end
            end else if (wr_byte[`CMD_HI6] == `CMD_TEMP_OP) begin
                TEMP_COEFF_MSB <= wr_byte[1]; // [R15]
                TEMP_COEFF_LSB <= wr_byte[0]; // [R15]
            end
        end
    end

    // refresh scan, paced by the display clock only
    reg [5:0] row_r;
    reg [6:0] scan_col_r;
    reg [COLS-1:0] line_r;
    wire [7:0] scan_byte =
        display_memory[mem_index(row_r[`ROW_BANK], scan_col_r)]; // [R10]
    wire scan_bit = scan_byte[row_r[`ROW_BIT]]; // [R23]
    wire [COLS-1:0] line_nxt = {scan_bit, line_r[COLS-1:1]};

    always @(posedge MCLK) begin
        if (!RESETN) begin
            row_r <= `ROW_RESET;
            scan_col_r <= `COL_RESET;
            scan_busy_r <= 1'b0;
            line_r <= {COLS{1'b0}};
            ROW_SELECT <= {ROWS{1'b0}};
            COLUMN_OUT <= {COLS{1'b0}};
        end else begin
            if (!scan_busy_r) begin
                if (dclk_rise) begin
                    scan_busy_r <= 1'b1; // [R17]
                    scan_col_r <= `COL_RESET;
                end
            end else begin
                line_r <= line_nxt; // [R18]
                if (scan_col_r == `COL_LAST) begin
                    scan_busy_r <= 1'b0;
                    if (row_r == `ROW_LAST) begin
                        row_r <= `ROW_RESET; // [R18]
                    end else begin
                        row_r <= row_r + 6'h01;
                    end
                end else begin
                    scan_col_r <= scan_col_r + 7'h01;
                end
            end
            if (POWER_DOWN_FLAG) begin
                ROW_SELECT <= {ROWS{1'b0}}; // [R16]
                COLUMN_OUT <= {COLS{1'b0}};
            end else if (scan_busy_r && scan_col_r == `COL_LAST) begin
                ROW_SELECT <= {{(ROWS-1){1'b0}}, 1'b1} << row_r; // [R18]
                COLUMN_OUT <= shape_row(DISPLAY_MODE, line_nxt); // [R14]
            end
        end
    end

endmodule

// ### lcd_serial_store_bench.sv
// self-checking bench for the serial display memory write block
`timescale 1ns/10ps
module lcd_serial_store_bench;
    reg mclk = 1'b0;
    reg resetn = 1'b0;
    reg dclk = 1'b0;
    wire sclk, serial_data_in, sel_n, dc, ovr;
    wire [16:0] st;
    reg [6:0] col;
    reg [2:0] bank;
    reg [1:0] dm, tc;
    reg v, h, pd;
    reg [31:0] rnd;
    reg [16:0] q[$];
    integer error_cnt = 0;
    integer total_checks = 0;
    integer seed = 32'h5b0f_1b67;
    integer i;
    event smp;
    always #25 mclk = ~mclk;
    always begin
        repeat (100) @(negedge mclk);
        dclk = ~dclk;
    end
    lcd_serial_store i_lcd_serial_store (.MCLK(mclk), .RESETN(resetn),
        .SERIAL_CLOCK(sclk), .SERIAL_DATA_IN(serial_data_in), .LINK_SELECT_N(sel_n),
        .DATA_MODE(dc), .DISPLAY_CLOCK_INPUT(dclk), .ROW_SELECT(),
        .COLUMN_OUT(), .COLUMN_ADDRESS(st[14:8]), .BANK_ADDRESS(st[7:5]),
        .VERTICAL_MODE(st[4]), .EXTENDED_SET(st[16]),
        .DISPLAY_MODE(st[3:2]), .POWER_DOWN_FLAG(st[15]),
        .TEMP_COEFF_MSB(st[1]), .TEMP_COEFF_LSB(st[0]),
        .BYTE_OVERRUN(ovr));
    link_host i_link_host (.mclk(mclk), .sclk(sclk), .serial_data_in(serial_data_in),
        .sel_n(sel_n), .dc(dc));
    task check(input [16:0] seen, input [16:0] exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[FAIL] status expected %h seen %h", exp, seen);
            end
        end
    endtask
    always @(smp) check(st, q.pop_front());
    task settle;
        begin
            q.push_back({h, pd, col, bank, v, dm, tc});
            repeat (100) @(negedge mclk);
            -> smp;
        end
    endtask
    task rst;
        begin
            resetn = 1'b0;
            repeat (6) @(negedge mclk);
            resetn = 1'b1;
            {h, pd, col, bank, v, dm, tc} = 17'h0_8000;
            settle;
        end
    endtask
    task xfer(input [7:0] b, input d);
        begin
            if (d) begin
                if (col == 7'h53 && bank == 3'h5) {col, bank} = 0;
                else if (v && bank == 3'h5) begin
                    bank = 3'h0;
                    col = col + 7'h01;
                end else if (v) bank = bank + 3'h1;
                else if (col == 7'h53) begin
                    col = 7'h00;
                    bank = bank + 3'h1;
                end else col = col + 7'h01;
            end else if (b[7:3] == 5'h04) {pd, v, h} = b[2:0];
            else if (!h && b[7]) col = b[6:0];
            else if (!h && b[7:3] == 5'h08) bank = b[2:0];
            else if (!h && b[7:3] == 5'h01) dm = {b[2], b[0]};
            else if (h && b[7:2] == 6'h01) tc = b[1:0];
            i_link_host.send(b, d, 8);
            settle;
        end
    endtask
    task dat;
        begin
            rnd = $random(seed);
            xfer(rnd[7:0], 1'b1);
        end
    endtask
    task tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", total_checks, error_cnt);
            if (error_cnt == 0 && total_checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    initial begin
        #2000000;
        error_cnt = error_cnt + 1;
        tally_and_finish;
    end
    initial begin
        rst;
        xfer(8'h20, 1'b0);
        xfer(8'hd2, 1'b0);
        xfer(8'h45, 1'b0);
        for (i = 0; i < 3; i = i + 1) dat;
        xfer(8'hd3, 1'b0);
        xfer(8'h40, 1'b0);
        xfer(8'h80, 1'b1);
        $display("horizontal addressing done");
        xfer(8'h22, 1'b0);
        xfer(8'h44, 1'b0);
        xfer(8'h8a, 1'b0);
        for (i = 0; i < 3; i = i + 1) dat;
        xfer(8'hd3, 1'b0);
        xfer(8'h45, 1'b0);
        dat;
        $display("vertical addressing done");
        i_link_host.send(8'h80, 1'b0, 4);
        xfer(8'hc5, 1'b0);
        for (i = 0; i < 4; i = i + 1) xfer({5'h01, i[1], 1'b0, i[0]}, 1'b0);
        xfer(8'h21, 1'b0);
        for (i = 0; i < 4; i = i + 1) xfer({6'h01, i[1:0]}, 1'b0);
        xfer(8'h85, 1'b0);
        dat;
        xfer(8'h20, 1'b0);
        $display("command set done");
        rst;
        dat;
        check({16'h0000, ovr}, 17'h0_0000);
        $display("reset done");
        repeat (2) @(negedge mclk);
        tally_and_finish;
    end
endmodule

// ### lcd_serial_store_checker.sv
// assertion checker for the serial display memory write block
`timescale 1ns/10ps
module lcd_serial_store_checker #(
    parameter COLS = 84,
    parameter ROWS = 48
) (
    input wire MCLK,
    input wire RESETN,
    input wire [ROWS-1:0] ROW_SELECT,
    input wire [COLS-1:0] COLUMN_OUT,
    input wire [6:0] COLUMN_ADDRESS,
    input wire [2:0] BANK_ADDRESS,
    input wire VERTICAL_MODE,
    input wire EXTENDED_SET,
    input wire [1:0] DISPLAY_MODE,
    input wire POWER_DOWN_FLAG,
    input wire TEMP_COEFF_MSB,
    input wire TEMP_COEFF_LSB
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);
    AST_RST_STATE: assert property (disable iff (1'b0)
        !RESETN |=> COLUMN_ADDRESS == 7'h00 && BANK_ADDRESS == 3'h0
        && !VERTICAL_MODE && POWER_DOWN_FLAG)
        else $error("reset state wrong");
    AST_ADDR_RANGE: assert property (
        COLUMN_ADDRESS <= 7'h53 && BANK_ADDRESS <= 3'h5)
        else $error("address out of range");
    AST_PD_DARK: assert property (
        POWER_DOWN_FLAG && $past(POWER_DOWN_FLAG) |->
        ROW_SELECT == 0 && COLUMN_OUT == 0)
        else $error("panel driven in power-down");
    AST_ROW_ONEHOT: assert property ($onehot0(ROW_SELECT))
        else $error("more than one row driven");
    AST_ROW_STEP: assert property (
        $past(RESETN) && !POWER_DOWN_FLAG && !$past(POWER_DOWN_FLAG)
        && $past(ROW_SELECT) != 0 && $changed(ROW_SELECT) |->
        ROW_SELECT == {$past(ROW_SELECT[ROWS-2:0]),
        $past(ROW_SELECT[ROWS-1])})
        else $error("row did not step by one");
    AST_COL_WITH_ROW: assert property (
        $past(RESETN) && !POWER_DOWN_FLAG && !$past(POWER_DOWN_FLAG)
        && $changed(COLUMN_OUT) |-> $changed(ROW_SELECT))
        else $error("columns changed without row step");
    AST_TC_EXT: assert property (
        $past(RESETN) && $changed({TEMP_COEFF_MSB, TEMP_COEFF_LSB})
        |-> $past(EXTENDED_SET))
        else $error("coefficient changed in basic set");
    AST_DM_BASIC: assert property (
        $past(RESETN) && $changed(DISPLAY_MODE) |-> !$past(EXTENDED_SET))
        else $error("display mode changed in extended set");
endmodule

bind lcd_serial_store lcd_serial_store_checker #(.COLS(COLS), .ROWS(ROWS))
    i_lcd_serial_store_checker (.MCLK(MCLK), .RESETN(RESETN),
    .ROW_SELECT(ROW_SELECT), .COLUMN_OUT(COLUMN_OUT),
    .COLUMN_ADDRESS(COLUMN_ADDRESS), .BANK_ADDRESS(BANK_ADDRESS),
    .VERTICAL_MODE(VERTICAL_MODE), .EXTENDED_SET(EXTENDED_SET),
    .DISPLAY_MODE(DISPLAY_MODE), .POWER_DOWN_FLAG(POWER_DOWN_FLAG),
    .TEMP_COEFF_MSB(TEMP_COEFF_MSB), .TEMP_COEFF_LSB(TEMP_COEFF_LSB));

// ### lcd_store_map.vh
// constants for the serial display memory write block
`ifndef LCD_STORE_MAP_VH
`define LCD_STORE_MAP_VH

// address ranges
`define COL_LAST 7'h53
`define BANK_LAST 3'h5
`define COL_COUNT 9'h054
`define ROW_LAST 6'h2f
`define ROW_BANK 5:3
`define ROW_BIT 2:0

// serial framing
`define BIT_LAST 3'h7
`define ENTRY_DC 8
`define ENTRY_BYTE 7:0

// command opcodes, upper bits
`define CMD_FSET_OP 5'h04
`define CMD_DCTL_OP 5'h01
`define CMD_SETY_OP 5'h08
`define CMD_TEMP_OP 6'h01
`define CMD_SETX_BIT 7
`define CMD_HI5 7:3
`define CMD_HI6 7:2

// command field positions
`define FS_PD 2
`define FS_V 1
`define FS_H 0
`define DC_D 2
`define DC_ZERO 1
`define DC_E 0
`define FLD_Y 2:0
`define FLD_X 6:0
`define FLD_TC 1:0

// display presentation, coded as {D,E}
`define DM_BLANK 2'h0
`define DM_ALLON 2'h1
`define DM_NORMAL 2'h2
`define DM_INVERSE 2'h3

// reset values
`define PD_RESET 1'b1
`define V_RESET 1'b0
`define H_RESET 1'b0
`define DM_RESET 2'h0
`define TC_RESET 2'h0
`define COL_RESET 7'h00
`define BANK_RESET 3'h0
`define ROW_RESET 6'h00

`endif

// ### link_host.sv
// host model driving the serial display link
`timescale 1ns/10ps
module link_host (
    input wire mclk,
    output reg sclk,
    output reg serial_data_in,
    output reg sel_n,
    output reg dc
);
    initial begin
        sclk = 1'b0;
        serial_data_in = 1'b0;
        sel_n = 1'b1;
        dc = 1'b0;
    end
    // sends the top n bits of b, 400 ns per bit
    task send(input [7:0] b, input d, input integer n);
        integer i;
        begin
            @(negedge mclk);
            sel_n = 1'b0;
            for (i = 7; i > 7 - n; i = i - 1) begin
                serial_data_in = b[i];
                dc = d;
                repeat (4) @(negedge mclk);
                sclk = 1'b1;
                repeat (4) @(negedge mclk);
                sclk = 1'b0;
            end
            sel_n = 1'b1;
            serial_data_in = ~serial_data_in;
            dc = ~dc;
            repeat (4) @(negedge mclk);
        end
    endtask
endmodule
